// [logic/pcfs_sequencer.sv]
// Program counter and instruction fetch sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "pcfs_consts.svh"

// Operation
// - Counter drives address for each fetch
// - Counter advances by one per sequential fetch
// - First byte decoded as the opcode
// - Absolute operand follows opcode via counter
// - Second fetch low, third fetch high
// - Three increments for three-byte non-jump instruction
// - Counter wraps from top to bottom
// - Jump loads low then high operand
// - Offsets relative to address after the offset byte
// - Low byte held until high arrives
// - Jump target addresses next opcode fetch
// - Jump alters only counter, no flags
// - Jump absolute or indirect by opcode
// - Jump always taken regardless of flags
// - Branch changes counter only on match
// - Untaken branch continues sequential fetch
// - Two byte halves form 16-bit counter
// - Offset added to next-instruction address
// - Offset is signed, bit seven backward
module pcfs_sequencer (
   input  wire logic                    clk_sys_i,
   input  wire logic                    sys_rst_i,
   input  wire logic                    run_i,
   input  wire logic [7:0]              mem_data_i,
   input  wire pcfs_pkg::pcfs_flags_type flags_i,
   output var  pcfs_pkg::pcfs_bus_type  mem_bus_o,
   output var  logic [15:0]             program_counter_o,
   output var  logic [7:0]              operation_code_byte_o,
   output var  logic                    opcode_strobe_o,
   output var  logic [15:0]             operand_addr_o,
   output var  logic                    operand_valid_o
);
   import pcfs_pkg::*;

   pcfs_regs_type r_reg;
   pcfs_regs_type r_next;

   // The counter halves carry into each other as one 16-bit word.
   function automatic logic [15:0] pc_of(input logic [7:0] hi, input logic [7:0] lo);
      pc_of = {hi, lo};
   endfunction

   function automatic logic [15:0] inc16(input logic [15:0] v);
      inc16 = 16'(v + 16'h0001);
   endfunction

   // Condition select bits pick the flag; the value bit gives the sense.
   function automatic logic cond_met(input logic [7:0] op, input pcfs_flags_type f);
      logic flag;
      flag = 1'b0;
      case (op[`PCFS_COND_SEL_HI:`PCFS_COND_SEL_LO])
         2'b00:   flag = f.negative;
         2'b01:   flag = f.overflow;
         2'b10:   flag = f.carry;
         default: flag = f.zero;
      endcase
      cond_met = (flag == op[`PCFS_COND_VAL_BIT]);
   endfunction

   logic [15:0] pc_now;
   logic [15:0] pc_inc;
   logic [15:0] branch_target;
   assign pc_now = pc_of(r_reg.counter_high_byte, r_reg.counter_low_byte);
   assign pc_inc = inc16(pc_now);
   // Sign-extend the offset and add to the address of the next opcode.
   assign branch_target = 16'(pc_inc + {{8{mem_data_i[`PCFS_SIGN_BIT]}}, mem_data_i});

   always_comb begin
      r_next = r_reg;
      r_next.opcode_strobe = 1'b0;
      r_next.operand_valid = 1'b0;
      r_next.bus.rd = 1'b0;
      if (run_i) begin
         // Each fetch presents the counter; sequential fetches then step it by one.
         r_next.bus.rd = 1'b1;
         case (r_reg.state)
            PCFS_ST_OPCODE: begin
               r_next.bus.addr = pc_now;
               r_next.operation_code_byte = mem_data_i;
               r_next.opcode_strobe = 1'b1;
               {r_next.counter_high_byte, r_next.counter_low_byte} = pc_inc;
               if ((mem_data_i & `PCFS_BRANCH_MASK) == `PCFS_BRANCH_CODE) begin
                  r_next.state = PCFS_ST_BRANCH;
               end else if ((mem_data_i & `PCFS_OP_ABS3_MASK) == `PCFS_OP_ABS3_MASK) begin
                  r_next.state = PCFS_ST_OPER1;
               end else begin
                  r_next.state = PCFS_ST_OPCODE;
               end
            end
            PCFS_ST_OPER1: begin
               r_next.bus.addr = pc_now;
               r_next.operand_temp = mem_data_i;
               {r_next.counter_high_byte, r_next.counter_low_byte} = pc_inc;
               r_next.state = PCFS_ST_OPER2;
            end
            PCFS_ST_OPER2: begin
               r_next.bus.addr = pc_now;
               if (r_reg.operation_code_byte == `PCFS_OP_JMP_ABS) begin
                  // Both halves load together; flags are never touched here.
                  r_next.counter_low_byte = r_reg.operand_temp;
                  r_next.counter_high_byte = mem_data_i;
                  r_next.state = PCFS_ST_OPCODE;
               end else if (r_reg.operation_code_byte == `PCFS_OP_JMP_IND) begin
                  r_next.indirect_ptr = {mem_data_i, r_reg.operand_temp};
                  // The pointer is parked in the counter so memory only ever follows one address.
                  {r_next.counter_high_byte, r_next.counter_low_byte} =
                     {mem_data_i, r_reg.operand_temp};
                  r_next.state = PCFS_ST_IND_LO;
               end else begin
                  r_next.operand_addr = {mem_data_i, r_reg.operand_temp};
                  r_next.operand_valid = 1'b1;
                  {r_next.counter_high_byte, r_next.counter_low_byte} = pc_inc;
                  r_next.state = PCFS_ST_OPCODE;
               end
            end
            PCFS_ST_IND_LO: begin
               r_next.bus.addr = pc_now;
               r_next.operand_temp = mem_data_i;
               r_next.indirect_ptr = inc16(r_reg.indirect_ptr);
               {r_next.counter_high_byte, r_next.counter_low_byte} = pc_inc;
               r_next.state = PCFS_ST_IND_HI;
            end
            PCFS_ST_IND_HI: begin
               r_next.bus.addr = pc_now;
               r_next.counter_low_byte = r_reg.operand_temp;
               r_next.counter_high_byte = mem_data_i;
               r_next.state = PCFS_ST_OPCODE;
            end
            PCFS_ST_BRANCH: begin
               r_next.bus.addr = pc_now;
               if (cond_met(r_reg.operation_code_byte, flags_i)) begin
                  {r_next.counter_high_byte, r_next.counter_low_byte} = branch_target;
               end else begin
                  {r_next.counter_high_byte, r_next.counter_low_byte} = pc_inc;
               end
               r_next.state = PCFS_ST_OPCODE;
            end
            default: begin
               r_next.state = PCFS_ST_OPCODE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         r_reg.state <= PCFS_ST_OPCODE;
         r_reg.counter_low_byte <= 8'(`PCFS_PC_RESET);
         r_reg.counter_high_byte <= 8'(`PCFS_PC_RESET >> 8);
         r_reg.operation_code_byte <= 8'h00;
         r_reg.operand_temp <= 8'h00;
         r_reg.indirect_ptr <= 16'h0000;
         r_reg.bus <= '0;
         r_reg.opcode_strobe <= 1'b0;
         r_reg.operand_addr <= 16'h0000;
         r_reg.operand_valid <= 1'b0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign mem_bus_o = r_reg.bus;
   assign program_counter_o = pc_now;
   assign operation_code_byte_o = r_reg.operation_code_byte;
   assign opcode_strobe_o = r_reg.opcode_strobe;
   assign operand_addr_o = r_reg.operand_addr;
   assign operand_valid_o = r_reg.operand_valid;
endmodule
`default_nettype wire

// [logic/pcfs_consts.svh]
// Constants for the program counter fetch sequencer.
`ifndef PCFS_CONSTS_SVH
`define PCFS_CONSTS_SVH
`define PCFS_PC_RESET       16'h0000
`define PCFS_OP_JMP_ABS     8'h4C
`define PCFS_OP_JMP_IND     8'h6C
`define PCFS_OP_ABS3_MASK   8'h0C
`define PCFS_BRANCH_MASK    8'h1F
`define PCFS_BRANCH_CODE    8'h10
`define PCFS_COND_SEL_HI    7
`define PCFS_COND_SEL_LO    6
`define PCFS_COND_VAL_BIT   5
`define PCFS_SIGN_BIT       7
`endif

// [logic/pcfs_pkg.sv]
// Types for the program counter fetch sequencer.
package pcfs_pkg;
   typedef struct packed {
      logic       negative;
      logic       overflow;
      logic       zero;
      logic       carry;
   } pcfs_flags_type;

   typedef struct packed {
      logic [15:0] addr;
      logic        rd;
   } pcfs_bus_type;

   typedef enum logic [6:0] {
      PCFS_ST_OPCODE = 7'b000_0001,
      PCFS_ST_OPER1  = 7'b000_0010,
      PCFS_ST_OPER2  = 7'b000_0100,
      PCFS_ST_BRANCH = 7'b000_1000,
      PCFS_ST_IND_LO = 7'b001_0000,
      PCFS_ST_IND_HI = 7'b010_0000,
      PCFS_ST_OPER1S = 7'b100_0000
   } pcfs_state_type;

   typedef struct packed {
      pcfs_state_type state;
      logic [7:0]     counter_low_byte;
      logic [7:0]     counter_high_byte;
      logic [7:0]     operation_code_byte;
      logic [7:0]     operand_temp;
      logic [15:0]    indirect_ptr;
      pcfs_bus_type   bus;
      logic           opcode_strobe;
      logic [15:0]    operand_addr;
      logic           operand_valid;
   } pcfs_regs_type;
endpackage

// [tb/pcfs_mem_model.sv]
// Combinational program memory that answers the sequencer's fetches.
`timescale 1ns/1ns
`default_nettype none
module pcfs_mem_model (
   input  wire logic [15:0] addr_i,
   output var  logic [7:0]  data_o
);
   logic [7:0] mem [0:65535];
   // The byte must be present in the same cycle because the fetch edge samples it.
   assign data_o = mem[addr_i];
endmodule
`default_nettype wire

// [tb/pcfs_props.sv]
// Port assertions for the fetch sequencer.
`timescale 1ns/1ns
`default_nettype none
module pcfs_props (
   input wire logic                     clk_sys_i,
   input wire logic                     sys_rst_i,
   input wire logic                     run_i,
   input wire logic [7:0]               mem_data_i,
   input wire pcfs_pkg::pcfs_flags_type flags_i,
   input wire pcfs_pkg::pcfs_bus_type   mem_bus_o,
   input wire logic [15:0]              program_counter_o,
   input wire logic [7:0]               operation_code_byte_o,
   input wire logic                     opcode_strobe_o
);
   import pcfs_pkg::*;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   logic [3:0] fv;
   assign fv = {flags_i.zero, flags_i.carry, flags_i.overflow, flags_i.negative};
   sequence jmp_fetch;
      opcode_strobe_o && operation_code_byte_o == 8'h4C && run_i ##1 run_i;
   endsequence
   sequence br_miss;
      opcode_strobe_o && (operation_code_byte_o & 8'h1F) == 8'h10 && run_i
         && fv[operation_code_byte_o[7:6]] != operation_code_byte_o[5];
   endsequence
   fetch_addr_a: assert property (mem_bus_o.rd
      |-> mem_bus_o.addr == $past(program_counter_o)) else $error("fetch address off");
   pc_step_a: assert property (opcode_strobe_o
      |-> program_counter_o == mem_bus_o.addr + 16'h0001) else $error("counter step off");
   stall_hold_a: assert property (!run_i
      |=> !mem_bus_o.rd && $stable(program_counter_o)) else $error("fetch while stalled");
   strobe_fetch_a: assert property (opcode_strobe_o |-> mem_bus_o.rd)
      else $error("strobe without fetch");
   jump_load_a: assert property (jmp_fetch
      |=> program_counter_o == {$past(mem_data_i), $past(mem_data_i, 2)}) else $error("bad target");
   jump_offset_a: assert property (jmp_fetch
      |=> mem_bus_o.addr == $past(mem_bus_o.addr, 2) + 16'h0002) else $error("bad operand");
   jump_target_a: assert property (jmp_fetch ##1 run_i
      |=> opcode_strobe_o && mem_bus_o.addr == $past(program_counter_o)) else $error("no jump");
   branch_miss_a: assert property (br_miss
      |=> program_counter_o == mem_bus_o.addr + 16'h0001) else $error("untaken branch moved");
endmodule
bind pcfs_sequencer pcfs_props pcfs_props_inst (.*);
`default_nettype wire

// [tb/test_program_counter_fetch_sequencer.sv]
// Self-checking bench for the fetch sequencer.
`timescale 1ns/1ns
`default_nettype none
module test_program_counter_fetch_sequencer;
   import pcfs_pkg::*;
   logic           clk_sys_i, sys_rst_i, run_i, opcode_strobe_o, operand_valid_o;
   logic [7:0]     mem_data_i, operation_code_byte_o, d, lo, op;
   logic [15:0]    program_counter_o, operand_addr_o, ex;
   pcfs_flags_type flags_i;
   pcfs_bus_type   mem_bus_o;
   int             error_cnt = 0, n_compared = 0, seed = 32'h9bca, ph, i;
   pcfs_sequencer pcfs_sequencer_inst (.clk_sys_i, .sys_rst_i, .run_i, .mem_data_i, .flags_i,
      .mem_bus_o, .program_counter_o, .operation_code_byte_o, .opcode_strobe_o,
      .operand_addr_o, .operand_valid_o);
   pcfs_mem_model pcfs_mem_model_inst (.addr_i(program_counter_o), .data_o(mem_data_i));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("errors %0d compares %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   function automatic logic taken(input logic [7:0] o, input pcfs_flags_type f);
      logic [3:0] v;
      v = {f.zero, f.carry, f.overflow, f.negative};
      return v[o[7:6]] == o[5];
   endfunction
   task automatic do_reset;
      sys_rst_i = 1;
      repeat (5) @(negedge clk_sys_i);
      sys_rst_i = 0;
      ex = 0;
      ph = 0;
   endtask
   // Flags change only after a non-branch opcode so a pending branch sees them stable.
   task automatic step;
      @(negedge clk_sys_i);
      if (mem_bus_o.rd === 1'b1) begin
         d = pcfs_mem_model_inst.mem[mem_bus_o.addr];
         chk(mem_bus_o.addr, ex, "fetch addr");
         ex = mem_bus_o.addr + 16'h0001;
         if (ph == 3) begin
            ph = 0;
            if (taken(op, flags_i)) ex = ex + {{8{d[7]}}, d};
         end else begin
            case (ph)
               0: begin
                  op = d;
                  chk(opcode_strobe_o, 1, "strobe");
                  chk(operation_code_byte_o, d, "opcode");
                  ph = ((d & 8'h1F) == 8'h10) ? 3 : ((d & 8'h0C) == 8'h0C) ? 1 : 0;
                  if (ph != 3) flags_i = 4'($random(seed));
               end
               1: begin
                  lo = d;
                  ph = 2;
               end
               2: begin
                  ph = 0;
                  chk(operand_valid_o, (op != 8'h4C) && (op != 8'h6C), "valid");
                  if (op == 8'h4C) ex = {d, lo};
                  else if (op == 8'h6C) begin
                     ex = {d, lo};
                     ph = 4;
                  end
                  else chk(operand_addr_o, {d, lo}, "operand");
               end
               4: begin
                  lo = d;
                  ph = 5;
               end
               default: begin
                  ph = 0;
                  ex = {d, lo};
               end
            endcase
            chk(program_counter_o, ex, "counter");
         end
      end
      run_i = ($random(seed) & 3) != 0;
   endtask
   initial begin
      clk_sys_i = 0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      #3_000_000;
      error_cnt++;
      end_of_test;
   end
   initial begin
      run_i = 0;
      flags_i = '0;
      for (i = 0; i < 65536; i++) begin
         d = $random(seed);
         pcfs_mem_model_inst.mem[i] = d;
      end
      // Jump to the top of memory, where a three-byte operand wraps past 0xFFFF.
      pcfs_mem_model_inst.mem[0] = 8'h4C;
      pcfs_mem_model_inst.mem[1] = 8'hFE;
      pcfs_mem_model_inst.mem[2] = 8'hFF;
      pcfs_mem_model_inst.mem[16'hFFFE] = 8'h0D;
      do_reset;
      repeat (20000) step;
      do_reset;
      repeat (5000) step;
      end_of_test;
   end
endmodule
`default_nettype wire
